/* common/llv_consts.svh */
`ifndef LLV_CONSTS_SVH
`define LLV_CONSTS_SVH

// Reference clock rate.
`define LLV_CLK_MHZ 125
// Times in nanoseconds, as specified.
`define LLV_STEADY_TOUT_NS 6000
`define LLV_STARTUP_TOUT_NS 100000
`define LLV_MODE_HOLD_NS 1000000
`define LLV_BURST_TIMER_NS 1250000
`define LLV_MIN_FREQ_PERIOD_NS 40000
`define LLV_MAX_DEAD_TIME_NS 36000
// Cycle counts derived from the times above.
`define LLV_CYC(ns) (((ns) * `LLV_CLK_MHZ) / 1000)
// Valley range and burst pulse minimum.
`define LLV_VALLEY_FIRST 3'h1
`define LLV_VALLEY_LAST 3'h6
`define LLV_VALLEY_RESET 3'h1
`define LLV_BURST_MIN_PULSES 2'h3
// Full scale of the foldback depth input.
`define LLV_DEPTH_SHIFT 8

`endif

/* common/llv_pkg.sv */
package llv_pkg;

	typedef logic [2:0] llv_valley_type;

	typedef enum logic [2:0] {
		LLV_CYC_WAIT = 3'h1,
		LLV_CYC_DEAD = 3'h2,
		LLV_CYC_PULSE = 3'h4
	} llv_cycle_type;

	typedef enum logic [2:0] {
		LLV_BST_RUN = 3'h1,
		LLV_BST_ON = 3'h2,
		LLV_BST_OFF = 3'h4
	} llv_burst_type;

endpackage

/* sim/llv_switch_model.sv */
module llv_switch_model (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// Drive and bench settings
	input wire logic gate_pulse_i,
	input wire logic [2:0] valleys_i,
	input wire logic [15:0] demag_cyc_i,
	// Sense back to the controller
	output logic pulse_end_o,
	output logic demag_done_o,
	output logic demag_sense_below_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int on_cnt;
	int off_cnt;
	int ring;
	// A damped ring shows only its first valleys_i dips; the later ones are lost.
	assign ring = off_cnt - int'(demag_cyc_i);
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			on_cnt <= 0;
			off_cnt <= 0;
			pulse_end_o <= 1'b0;
			demag_done_o <= 1'b0;
			demag_sense_below_o <= 1'b0;
		end else if (gate_pulse_i) begin
			on_cnt <= on_cnt + 1;
			off_cnt <= 0;
			pulse_end_o <= on_cnt >= 19;
			demag_done_o <= 1'b0;
			demag_sense_below_o <= 1'b0;
		end else begin
			on_cnt <= 0;
			off_cnt <= off_cnt + 1;
			pulse_end_o <= 1'b0;
			demag_done_o <= ring >= 0;
			demag_sense_below_o <= ring > 0 && ring % 40 > 37 && ring / 40 < int'(valleys_i);
		end
	end
endmodule

/* sim/tb.sv */
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import llv_pkg::*;
	localparam int FALL[5] = '{1400, 1200, 1100, 1000, 900};
	localparam int RISE[5] = '{2000, 1800, 1700, 1600, 1500};
	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic soft_start_i = 1'b0;
	logic [7:0] fold_depth_i = 8'h00;
	logic [2:0] valleys = 3'h6;
	logic [15:0] demag_cyc = 16'h0032;
	logic [4:0] fb_below_fall;
	logic [4:0] fb_above_rise;
	logic pulse_end_i, demag_done_i, demag_sense_below_i;
	logic gate_pulse_o, min_peak_modulation_o, burst_mode_o;
	llv_valley_type valley_hold_o;
	logic [7:0] peak_scale_o;
	logic [31:0] seed = 32'h0000EB5B;
	int fb_mv = 2100;
	int mismatches = 0;
	int check_count = 0;
	int cyc = 0;
	int t_valley, t_end, w0, r, k, t0;
	int rise_q[$];

	always_comb begin
		for (int i = 0; i < 5; i++) begin
			fb_below_fall[i] = fb_mv < FALL[i];
			fb_above_rise[i] = fb_mv > RISE[i];
		end
	end

	llv_valley_skip #(.STARTUP_TOUT_CYC(200), .MODE_HOLD_CYC(100), .BURST_TIMER_CYC(3000),
		.MIN_FREQ_CYC(3000), .MAX_DEAD_CYC(256)) llv_valley_skip_inst (
		.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.fb_below_fall_i(fb_below_fall), .fb_above_rise_i(fb_above_rise),
		.fb_below_entry_i(fb_mv < 800), .fb_above_exit_i(fb_mv > 750),
		.fb_below_skip_i(fb_mv < 300), .fb_above_skip_exit_i(fb_mv > 350),
		.fb_above_burst_exit_i(fb_mv > 1000), .fold_depth_i(fold_depth_i),
		.demag_sense_below_i(demag_sense_below_i), .demag_done_i(demag_done_i),
		.pulse_end_i(pulse_end_i), .soft_start_i(soft_start_i),
		.gate_pulse_o(gate_pulse_o), .valley_hold_o(valley_hold_o),
		.min_peak_modulation_o(min_peak_modulation_o), .peak_scale_o(peak_scale_o),
		.burst_mode_o(burst_mode_o));

	llv_switch_model llv_switch_model_inst (
		.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .gate_pulse_i(gate_pulse_o),
		.valleys_i(valleys), .demag_cyc_i(demag_cyc), .pulse_end_o(pulse_end_i),
		.demag_done_o(demag_done_i), .demag_sense_below_o(demag_sense_below_i));

	initial begin
		forever #4 ref_clk_i = ~ref_clk_i;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	function automatic int step(input int v, input int mv);
		if (v < 6 && mv < FALL[v - 1]) return v + 1;
		if (v > 1 && mv > RISE[v - 2]) return v - 1;
		return v;
	endfunction

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic check_in(input int got, input int lo, input int hi);
		check_count++;
		if (got < lo || got > hi) begin
			mismatches++;
			$display("wrong value at %0t: got %0h expected %0h to %0h", $time, got, lo, hi);
		end
	endtask

	task automatic cycles(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask

	// Bounded so that a design which never pulses still reaches the verdict.
	task automatic wait_rise(input int n);
		int w;
		w = 0;
		while (rise_q.size() < n && w < 8000) begin
			@(negedge ref_clk_i);
			w++;
		end
	endtask

	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 60000) begin
			mismatches++;
			print_verdict();
		end
	end
	always @(posedge gate_pulse_o) rise_q.push_back(cyc);
	always @(negedge gate_pulse_o) t_end = cyc;
	always @(posedge demag_sense_below_i) t_valley = cyc;

	initial begin
		int v;
		int lv[7] = '{1300, 1900, 2100, 950, 1450, 850, 1550};
		cycles(4);
		sys_rst_i = 1'b0;
		check(8'(valley_hold_o), 8'h01);
		check(peak_scale_o, 8'hFF);
		check(8'({gate_pulse_o, min_peak_modulation_o, burst_mode_o}), 8'h00);
		v = 1;
		foreach (lv[i]) begin
			fb_mv = lv[i];
			repeat (8) v = step(v, fb_mv);
			cycles(10);
			check(8'(valley_hold_o), 8'(v));
		end
		$display("test valley selection done");
		for (k = 4; k >= 3; k--) begin
			valleys = 3'(k);
			wait_rise(rise_q.size() + 2);
			check_in(rise_q[$] - t_valley, (5 - k) * 750 - 2, (5 - k) * 750 + 3);
		end
		valleys = 3'h0;
		fb_mv = 2100;
		for (k = 1; k >= 0; k--) begin
			soft_start_i = k[0];
			wait_rise(rise_q.size() + 2);
			check_in(rise_q[$] - t_end, k ? 190 : 740, k ? 260 : 810);
		end
		fb_mv = 850;
		wait_rise(rise_q.size() + 2);
		check_in(rise_q[$] - rise_q[$ - 1], 2998, 3003);
		demag_cyc = 16'h0C80;
		wait_rise(rise_q.size() + 2);
		check_in(rise_q[$] - t_end, 3199, 3204);
		demag_cyc = 16'h0032;
		$display("test timeouts done");
		seed = xs(seed);
		fold_depth_i = seed[7:0];
		r = int'(fold_depth_i);
		valleys = 3'h6;
		fb_mv = 780;
		cycles(4);
		check(8'(min_peak_modulation_o), 8'h01);
		check(peak_scale_o, 8'hFF - fold_depth_i);
		fb_mv = 770;
		cycles(40);
		check(8'(min_peak_modulation_o), 8'h01);
		cycles(80);
		check(8'(min_peak_modulation_o), 8'h00);
		fb_mv = 780;
		cycles(110);
		fb_mv = 1550;
		cycles(4);
		check(8'(min_peak_modulation_o), 8'h00);
		fb_mv = 780;
		cycles(120);
		wait_rise(rise_q.size() + 2);
		check_in(rise_q[$] - t_valley, r - 1, r + 3);
		$display("test foldback done");
		wait_rise(rise_q.size() + 1);
		cycles(40);
		w0 = t_end - rise_q[$];
		wait_rise(rise_q.size() + 1);
		fb_mv = 200;
		cycles(40);
		check_in(t_end - rise_q[$], w0, w0);
		k = rise_q.size();
		cycles(400);
		check_in(rise_q.size(), k, k);
		check(8'(burst_mode_o), 8'h01);
		t0 = cyc;
		fb_mv = 400;
		wait_rise(k + 1);
		fb_mv = 200;
		cycles(2000);
		check_in(rise_q.size() - k, 3, 3);
		fb_mv = 400;
		wait_rise(k + 4);
		check_in(rise_q[$] - t0, 3000, 4000);
		k = rise_q.size() - 1;
		fb_mv = 200;
		cycles(3600);
		check_in(rise_q.size() - k, 3, 3);
		t0 = cyc;
		fb_mv = 400;
		wait_rise(k + 4);
		check_in(rise_q[$] - t0, 1, 800);
		fb_mv = 200;
		cycles(1800);
		k = rise_q.size();
		fb_mv = 1100;
		cycles(4);
		check(8'(burst_mode_o), 8'h00);
		cycles(700);
		check_in(rise_q.size() - k, 1, 10);
		$display("test burst done");
		print_verdict();
	end
endmodule

/* verilog/llv_valley_skip.sv */
`include "llv_consts.svh"

module llv_valley_skip #(
	parameter int STARTUP_TOUT_CYC = `LLV_CYC(`LLV_STARTUP_TOUT_NS),
	parameter int MODE_HOLD_CYC = `LLV_CYC(`LLV_MODE_HOLD_NS),
	parameter int BURST_TIMER_CYC = `LLV_CYC(`LLV_BURST_TIMER_NS),
	parameter int MIN_FREQ_CYC = `LLV_CYC(`LLV_MIN_FREQ_PERIOD_NS),
	parameter int MAX_DEAD_CYC = `LLV_CYC(`LLV_MAX_DEAD_TIME_NS),
	parameter int CNT_W = 24
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// Feedback comparator flags and foldback depth
	input wire logic [4:0] fb_below_fall_i,
	input wire logic [4:0] fb_above_rise_i,
	input wire logic fb_below_entry_i,
	input wire logic fb_above_exit_i,
	input wire logic fb_below_skip_i,
	input wire logic fb_above_skip_exit_i,
	input wire logic fb_above_burst_exit_i,
	input wire logic [7:0] fold_depth_i,
	// Switch and winding sense
	input wire logic demag_sense_below_i,
	input wire logic demag_done_i,
	input wire logic pulse_end_i,
	input wire logic soft_start_i,
	// Drive and status
	output logic gate_pulse_o,
	output llv_pkg::llv_valley_type valley_hold_o,
	output logic min_peak_modulation_o,
	output logic [7:0] peak_scale_o,
	output logic burst_mode_o
);
	import llv_pkg::*;

	localparam int STEADY_TOUT_CYC = `LLV_CYC(`LLV_STEADY_TOUT_NS);

	llv_cycle_type cyc_state;
	llv_burst_type bst_state;
	llv_valley_type valley_hold;
	logic [2:0] valley_cnt;
	logic demag_prev;
	logic [CNT_W-1:0] tout_cnt;
	logic [CNT_W-1:0] cycle_cnt;
	logic [CNT_W-1:0] dead_cnt;
	logic [CNT_W-1:0] hold_cnt;
	logic [CNT_W-1:0] burst_cnt;
	logic [1:0] burst_pulses;
	logic skip_pending;
	logic fold;

	// Selects the comparator flag of the step that leaves a given valley.
	function automatic logic step_flag(input logic [4:0] flags, input llv_valley_type idx);
		step_flag = (idx <= 3'h4) ? flags[idx] : 1'b0;
	endfunction

	// Valley sources and timeouts.
	logic demag_edge;
	logic [CNT_W-1:0] tout_limit;
	logic tout_hit;
	logic valley_evt;
	logic valley_reached;
	logic pulses_allowed;
	logic min_freq_force;
	logic [CNT_W-1:0] dead_target;
	logic [31:0] dead_product;
	logic start_pulse;
	logic hold_done;
	logic burst_timer_done;
	logic fold_enter;
	logic fold_exit;

	assign demag_edge = demag_sense_below_i && !demag_prev;
	assign tout_limit = soft_start_i ? CNT_W'(STARTUP_TOUT_CYC - 1)
		: CNT_W'(STEADY_TOUT_CYC - 1);
	assign tout_hit = (cyc_state == LLV_CYC_WAIT) && (tout_cnt >= tout_limit);
	assign valley_evt = (cyc_state == LLV_CYC_WAIT) && (demag_edge || tout_hit);
	// Compared one bit wider so that a saturated count still reaches the valley.
	assign valley_reached = valley_evt
		&& (({1'b0, valley_cnt} + 4'h1) >= {1'b0, valley_hold});
	assign pulses_allowed = (bst_state != LLV_BST_OFF);
	assign min_freq_force = (cycle_cnt >= CNT_W'(MIN_FREQ_CYC - 1))
		&& demag_done_i && (cyc_state != LLV_CYC_PULSE);
	assign dead_product = 32'(fold_depth_i) * 32'(MAX_DEAD_CYC);
	assign dead_target = CNT_W'(dead_product >> `LLV_DEPTH_SHIFT);
	assign start_pulse = pulses_allowed && (min_freq_force
		|| (cyc_state == LLV_CYC_WAIT && valley_reached && !fold)
		|| (cyc_state == LLV_CYC_DEAD && dead_cnt >= dead_target));
	assign hold_done = (hold_cnt == '0);
	assign burst_timer_done = (burst_cnt == '0);

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			demag_prev <= 1'b0;
		end else begin
			demag_prev <= demag_sense_below_i;
		end
	end

	// Timeout runs from entry to the wait state or from the last detected valley; each expiry restarts it.
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tout_cnt <= '0;
		end else if (cyc_state != LLV_CYC_WAIT || demag_edge || tout_hit) begin
			tout_cnt <= '0;
		end else begin
			tout_cnt <= tout_cnt + CNT_W'(1);
		end
	end

	// Valley selection with hysteresis; only one step per clock.
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			valley_hold <= `LLV_VALLEY_RESET;
		end else if (valley_hold < `LLV_VALLEY_LAST
			&& step_flag(fb_below_fall_i, valley_hold - 3'h1)) begin
			valley_hold <= valley_hold + 3'h1;
		end else if (valley_hold > `LLV_VALLEY_FIRST
			&& step_flag(fb_above_rise_i, valley_hold - 3'h2)) begin
			valley_hold <= valley_hold - 3'h1;
		end
	end

	// Switching cycle sequencer.
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cyc_state <= LLV_CYC_WAIT;
			valley_cnt <= '0;
			dead_cnt <= '0;
		end else begin
			case (cyc_state)
				LLV_CYC_PULSE: begin
					// The pulse always runs to its natural end.
					if (pulse_end_i) begin
						cyc_state <= LLV_CYC_WAIT;
						valley_cnt <= '0;
					end
				end
				LLV_CYC_WAIT: begin
					if (start_pulse) begin
						cyc_state <= LLV_CYC_PULSE;
					end else if (valley_reached && fold) begin
						cyc_state <= LLV_CYC_DEAD;
						dead_cnt <= '0;
					end else if (valley_evt && valley_cnt != 3'h7) begin
						valley_cnt <= valley_cnt + 3'h1;
					end
				end
				LLV_CYC_DEAD: begin
					if (start_pulse) begin
						cyc_state <= LLV_CYC_PULSE;
					end else if (!fold) begin
						cyc_state <= LLV_CYC_WAIT;
					end else if (dead_cnt < dead_target) begin
						dead_cnt <= dead_cnt + CNT_W'(1);
					end
				end
				default: begin
					cyc_state <= LLV_CYC_WAIT;
				end
			endcase
		end
	end

	// Period timer from pulse start; saturates so a long stall cannot wrap.
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cycle_cnt <= '0;
		end else if (start_pulse) begin
			cycle_cnt <= '0;
		end else if (cycle_cnt != '1) begin
			cycle_cnt <= cycle_cnt + CNT_W'(1);
		end
	end

	// Foldback mode with entry and exit hysteresis plus a hold timer.
	assign fold_enter = !fold && hold_done && valley_hold == `LLV_VALLEY_LAST
		&& fb_below_entry_i && !fb_below_skip_i;
	assign fold_exit = fold && ((hold_done && fb_above_exit_i)
		|| fb_below_skip_i || fb_above_rise_i[4]);

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			fold <= 1'b0;
			hold_cnt <= '0;
		end else if (fold_enter || fold_exit) begin
			fold <= fold_enter;
			hold_cnt <= CNT_W'(MODE_HOLD_CYC - 1);
		end else if (!hold_done) begin
			hold_cnt <= hold_cnt - CNT_W'(1);
		end
	end

	// Burst sequencer; the skip request is latched because feedback may recover mid-pulse.
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			bst_state <= LLV_BST_RUN;
			skip_pending <= 1'b0;
			burst_pulses <= '0;
			burst_cnt <= '0;
		end else begin
			if (!burst_timer_done) begin
				burst_cnt <= burst_cnt - CNT_W'(1);
			end
			case (bst_state)
				LLV_BST_RUN: begin
					if (fb_below_skip_i || skip_pending) begin
						skip_pending <= 1'b1;
						if (cyc_state != LLV_CYC_PULSE) begin
							bst_state <= LLV_BST_OFF;
							skip_pending <= 1'b0;
						end
					end
				end
				LLV_BST_ON: begin
					if (cyc_state == LLV_CYC_PULSE && pulse_end_i
						&& burst_pulses != `LLV_BURST_MIN_PULSES) begin
						burst_pulses <= burst_pulses + 2'h1;
					end
					if (fb_above_burst_exit_i) begin
						bst_state <= LLV_BST_RUN;
						skip_pending <= 1'b0;
					end else if (fb_below_skip_i || skip_pending) begin
						skip_pending <= 1'b1;
						if (cyc_state != LLV_CYC_PULSE
							&& burst_pulses == `LLV_BURST_MIN_PULSES) begin
							bst_state <= LLV_BST_OFF;
							skip_pending <= 1'b0;
						end
					end
				end
				LLV_BST_OFF: begin
					if (fb_above_burst_exit_i) begin
						bst_state <= LLV_BST_RUN;
					end else if (fb_above_skip_exit_i && burst_timer_done) begin
						bst_state <= LLV_BST_ON;
						burst_pulses <= '0;
						burst_cnt <= CNT_W'(BURST_TIMER_CYC - 1);
					end
				end
				default: begin
					bst_state <= LLV_BST_RUN;
				end
			endcase
		end
	end

	// Outputs.
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			peak_scale_o <= 8'hFF;
		end else if (fold) begin
			peak_scale_o <= 8'hFF - fold_depth_i;
		end else begin
			peak_scale_o <= 8'hFF;
		end
	end

	assign gate_pulse_o = (cyc_state == LLV_CYC_PULSE);
	assign valley_hold_o = valley_hold;
	assign min_peak_modulation_o = fold;
	assign burst_mode_o = (bst_state != LLV_BST_RUN);

	// Checks.
	// Cycles since foldback last changed, kept apart from the mode's own hold counter.
	logic fold_q;
	logic [CNT_W-1:0] fold_age;
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			fold_q <= 1'b0;
			fold_age <= '1;
		end else begin
			fold_q <= fold;
			if (fold != fold_q) begin
				fold_age <= '0;
			end else if (fold_age != '1) begin
				fold_age <= fold_age + CNT_W'(1);
			end
		end
	end

	valley_range_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		valley_hold >= `LLV_VALLEY_FIRST && valley_hold <= `LLV_VALLEY_LAST)
		else $error("valley selection out of range");
	valley_step_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(valley_hold == 3'h2 && fb_below_fall_i[1]) |=> valley_hold == 3'h3)
		else $error("valley did not step on falling threshold");
	fold_entry_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		$rose(fold) |-> $past(valley_hold) == `LLV_VALLEY_LAST && $past(fb_below_entry_i))
		else $error("foldback entered without sixth valley and low feedback");
	dead_blank_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		cyc_state == LLV_CYC_DEAD |-> $past(fold))
		else $error("dead-time inserted outside foldback");
	fold_hold_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		($changed(fold) && !fb_below_skip_i && !fb_above_rise_i[4]) |=> $stable(fold))
		else $error("mode changed inside hold time");
	hold_span_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		($changed(fold) && !$past(fb_below_skip_i) && !$past(fb_above_rise_i[4]))
		|-> fold_age >= CNT_W'(MODE_HOLD_CYC - 1))
		else $error("foldback changed before hold time ran out");
	fold_fast_exit_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(fold && fb_below_skip_i) |=> !fold)
		else $error("foldback not left at skip level");
	pulse_whole_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(gate_pulse_o && !pulse_end_i) |=> gate_pulse_o)
		else $error("gate pulse truncated");
	forced_demag_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		$rose(gate_pulse_o) && $past(cycle_cnt) >= CNT_W'(MIN_FREQ_CYC - 1)
		|-> $past(demag_done_i) || $past(valley_evt) || $past(cyc_state) == LLV_CYC_DEAD)
		else $error("forced cycle before demagnetization");
	off_gate_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(bst_state == LLV_BST_OFF && !burst_timer_done) |=> bst_state != LLV_BST_ON)
		else $error("burst restarted before timer expiry");
	burst_min_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		($past(bst_state) == LLV_BST_ON && bst_state == LLV_BST_OFF)
		|-> $past(burst_pulses) == `LLV_BURST_MIN_PULSES)
		else $error("burst stopped before three pulses");
	burst_leave_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(bst_state != LLV_BST_RUN && fb_above_burst_exit_i) |=> bst_state == LLV_BST_RUN)
		else $error("burst not left above one volt");

	fold_seen_c: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		cyc_state == LLV_CYC_DEAD ##[1:1000] gate_pulse_o);
	burst_cycle_c: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		bst_state == LLV_BST_ON ##[1:1000] bst_state == LLV_BST_OFF);
	tout_valley_c: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		tout_hit && valley_reached);

endmodule
